// [logic/lpps_top.sv]
// The register offsets and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ns
// Pin-state control across reset, run, standby and backup-supply states
module lpps_top
  import lpps_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [3:0] op_state_in,
  input wire logic [NUM_PINS-1:0] periph_out,
  input wire logic [NUM_PINS-1:0] periph_oe,
  input wire logic [NUM_PINS-1:0] pad_in,
  output logic [NUM_PINS-1:0] pad_out,
  output logic [NUM_PINS-1:0] pad_oe,
  output logic [NUM_PINS-1:0] core_in,
  output logic [NUM_PINS-1:0] analog_en,
  output logic [NUM_PINS-1:0] wakeup_en,
  output logic main_osc_en,
  output logic sub_osc_en
);
  lpps_state_t state_reg;
  lpps_state_t state_next;
  logic standby_pin_level_bit_reg;
  logic sub_osc_stop_control_bit_reg;
  logic [NUM_PINS-1:0] gpio_out_reg;
  logic [NUM_PINS-1:0] gpio_dir_reg;
  logic [31:0] pin_func_reg;
  logic aw_full_reg;
  logic w_full_reg;
  logic [4:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic do_write;
  logic wr_hit;
  logic [31:0] rd_data;
  logic rd_hit;
  logic in_standby;
  logic in_timer;
  logic in_deep;
  logic in_vbat;

  // Byte-lane merge for strobed writes
  function automatic logic [31:0] lpps_merge(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0] strb
  );
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
        res[b*8 +: 8] = new_v[b*8 +: 8];
    end
    return res;
  endfunction : lpps_merge

  // Unknown state codes fall back to the power-on column, the safest one
  always_comb
  begin
    unique case (op_state_in)
      ST_EXT_RESET, ST_INT_RESET, ST_RUN, ST_TIMER, ST_SUB_TIMER,
      ST_SUBCR_TIMER, ST_RTC, ST_STOP, ST_DS_RTC, ST_DS_STOP,
      ST_DS_RETURN, ST_VBAT_RTC, ST_VBAT_RETURN:
        state_next = lpps_state_t'(op_state_in);
      default:
        state_next = ST_POR;
    endcase
  end

  // Operating state tracked every clock so pins update on each change
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      state_reg <= ST_POR;
    else
      state_reg <= state_next;
  end

  // State groups
  assign in_timer = (state_reg == ST_TIMER) || (state_reg == ST_SUB_TIMER)
    || (state_reg == ST_SUBCR_TIMER);
  assign in_standby = in_timer || (state_reg == ST_RTC) || (state_reg == ST_STOP);
  assign in_deep = (state_reg == ST_DS_RTC) || (state_reg == ST_DS_STOP);
  assign in_vbat = (state_reg == ST_VBAT_RTC) || (state_reg == ST_VBAT_RETURN);

  // Main oscillator runs only outside the low-clock modes
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      main_osc_en <= 1'b1;
    else
      main_osc_en <= !((state_reg == ST_SUB_TIMER) || (state_reg == ST_SUBCR_TIMER)
        || (state_reg == ST_RTC) || (state_reg == ST_STOP) || in_deep);
  end

  // Sub oscillator stops only when allowed and in a stop mode
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      sub_osc_en <= 1'b1;
    else
      sub_osc_en <= !(sub_osc_stop_control_bit_reg
        && ((state_reg == ST_STOP) || (state_reg == ST_DS_STOP)));
  end

  // Write channel acceptance; address and data may come in either order
  assign s_axi_awready = !aw_full_reg;
  assign s_axi_wready = !w_full_reg;
  assign do_write = aw_full_reg && w_full_reg && !s_axi_bvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full_reg <= 1'b0;
      aw_addr_reg <= 5'h00;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_full_reg <= 1'b1;
      aw_addr_reg <= s_axi_awaddr[4:0];
    end
    else if (do_write)
      aw_full_reg <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_full_reg <= 1'b0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_full_reg <= 1'b1;
      w_data_reg <= s_axi_wdata;
      w_strb_reg <= s_axi_wstrb;
    end
    else if (do_write)
      w_full_reg <= 1'b0;
  end

  // Only the five writable words answer OKAY
  always_comb
  begin
    unique case (aw_addr_reg)
      OFS_STANDBY_CTL, OFS_SUB_OSC_CTL, OFS_GPIO_OUT, OFS_GPIO_DIR, OFS_PIN_FUNC:
        wr_hit = 1'b1;
      default:
        wr_hit = 1'b0;
    endcase
  end

  // Write response one cycle after both halves are in
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end
    else if (do_write)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // Control registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      standby_pin_level_bit_reg <= 1'b0;
      sub_osc_stop_control_bit_reg <= 1'b0;
      gpio_out_reg <= GPIO_RST;
      gpio_dir_reg <= GPIO_RST;
      pin_func_reg <= PIN_FUNC_RST;
    end
    else if (do_write)
    begin
      if (aw_addr_reg == OFS_STANDBY_CTL && w_strb_reg[0])
        standby_pin_level_bit_reg <= w_data_reg[LEVEL_BIT_POS];
      if (aw_addr_reg == OFS_SUB_OSC_CTL && w_strb_reg[0])
        sub_osc_stop_control_bit_reg <= w_data_reg[SOSC_STOP_POS];
      if (aw_addr_reg == OFS_GPIO_OUT && w_strb_reg[0])
        gpio_out_reg <= w_data_reg[7:0];
      if (aw_addr_reg == OFS_GPIO_DIR && w_strb_reg[0])
        gpio_dir_reg <= w_data_reg[7:0];
      if (aw_addr_reg == OFS_PIN_FUNC)
        pin_func_reg <= lpps_merge(pin_func_reg, w_data_reg, w_strb_reg);
    end
  end

  // Read decode
  always_comb
  begin
    rd_data = 32'h0000_0000;
    rd_hit = 1'b1;
    unique case (s_axi_araddr[4:0])
      OFS_STANDBY_CTL:
        rd_data[LEVEL_BIT_POS] = standby_pin_level_bit_reg;
      OFS_SUB_OSC_CTL:
        rd_data[SOSC_STOP_POS] = sub_osc_stop_control_bit_reg;
      OFS_GPIO_OUT:
        rd_data[7:0] = gpio_out_reg;
      OFS_GPIO_DIR:
        rd_data[7:0] = gpio_dir_reg;
      OFS_PIN_FUNC:
        rd_data = pin_func_reg;
      OFS_STATUS:
      begin
        rd_data[3:0] = state_reg;
        rd_data[STAT_MAIN_OSC_POS] = main_osc_en;
        rd_data[STAT_SUB_OSC_POS] = sub_osc_en;
        rd_data[STAT_LEVEL_POS] = standby_pin_level_bit_reg;
      end
      OFS_PIN_IN:
        rd_data[7:0] = core_in;
      OFS_PIN_OE:
        rd_data[7:0] = pad_oe;
      default:
        rd_hit = 1'b0;
    endcase
  end

  // Read answer one cycle after the address is taken
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_data;
      s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // Per-pin state selection
  for (genvar i = 0; i < NUM_PINS; i++)
  begin : g_pin
    lpps_func_t fn;
    logic d_out;
    logic d_oe;
    logic d_din;
    logic d_ana;
    logic d_wk;
    logic d_hold;

    assign fn = lpps_func_t'(pin_func_reg[i*FUNC_W +: FUNC_W]);

    // Default is Hi-Z with the internal input forced low
    always_comb
    begin
      d_out = 1'b0;
      d_oe = 1'b0;
      d_din = 1'b0;
      d_ana = 1'b0;
      d_wk = 1'b0;
      d_hold = 1'b0;
      unique case (fn)
        FN_ANA_IN:
          d_ana = (state_reg != ST_POR);
        FN_SOSC_IN:
          d_din = 1'b1;
        FN_SOSC_OUT:
        begin
          // Oscillator keeps driving until it has really stopped
          if (state_reg != ST_POR)
          begin
            d_hold = sub_osc_en;
            d_out = periph_out[i];
            d_oe = periph_oe[i] && sub_osc_en;
            d_din = 1'b1;
          end
        end
        default:
        begin
          if (state_reg == ST_EXT_RESET || state_reg == ST_INT_RESET)
            d_din = (fn == FN_GPIO) || (fn == FN_RESOURCE) || (fn == FN_EXT_INT);
          else if (state_reg == ST_RUN || in_vbat)
          begin
            d_hold = in_vbat;
            d_out = (fn == FN_GPIO) ? gpio_out_reg[i] : periph_out[i];
            d_oe = (fn == FN_GPIO) ? gpio_dir_reg[i] : periph_oe[i] && (fn != FN_ANA_OUT);
            d_din = (fn != FN_ANA_OUT);
            d_ana = (fn == FN_ANA_OUT);
            d_wk = (fn == FN_WAKEUP);
          end
          else if (in_standby)
          begin
            if (fn == FN_ANA_OUT)
            begin
              d_hold = in_timer;
              d_out = gpio_out_reg[i];
              d_oe = gpio_dir_reg[i] && !standby_pin_level_bit_reg;
            end
            else if (fn == FN_TRACE && standby_pin_level_bit_reg)
            begin
              d_out = periph_out[i];
              d_oe = periph_oe[i];
            end
            else if (fn == FN_GPIO || fn == FN_RESOURCE)
              d_hold = !standby_pin_level_bit_reg;
            else
              d_hold = 1'b1;
          end
          else if (in_deep)
          begin
            if (fn == FN_WAKEUP)
            begin
              d_wk = 1'b1;
              d_hold = !standby_pin_level_bit_reg;
            end
            else if (!standby_pin_level_bit_reg)
            begin
              d_out = gpio_out_reg[i];
              d_oe = gpio_dir_reg[i];
            end
          end
          else if (state_reg == ST_DS_RETURN)
          begin
            d_wk = (fn == FN_WAKEUP);
            if (fn == FN_GPIO)
            begin
              d_out = gpio_out_reg[i];
              d_oe = gpio_dir_reg[i];
              d_din = 1'b1;
            end
          end
        end
      endcase
    end

    // A running peripheral is re-sampled rather than frozen, except in ST_VBAT_RTC
    lpps_pin_cell u_cell (
      .aclk(aclk),
      .aresetn(aresetn),
      .hold(d_hold && !(fn == FN_RESOURCE && state_reg != ST_VBAT_RTC
        && periph_oe[i] && !in_deep)),
      .out_next(fn == FN_RESOURCE ? periph_out[i] : d_out),
      .oe_next(fn == FN_RESOURCE && d_hold ? periph_oe[i] : d_oe),
      .din_en_next(d_din),
      .ana_next(d_ana),
      .wk_next(d_wk),
      .pad_in(pad_in[i]),
      .pad_out(pad_out[i]),
      .pad_oe(pad_oe[i]),
      .core_in(core_in[i]),
      .analog_en(analog_en[i]),
      .wakeup_en(wakeup_en[i])
    );
  end
endmodule : lpps_top

// [inc/lpps_pkg.sv]
package lpps_pkg;
  localparam int NUM_PINS = 8;
  localparam int FUNC_W = 4;
  // Register byte offsets
  localparam logic [4:0] OFS_STANDBY_CTL = 5'h00;
  localparam logic [4:0] OFS_SUB_OSC_CTL = 5'h04;
  localparam logic [4:0] OFS_GPIO_OUT = 5'h08;
  localparam logic [4:0] OFS_GPIO_DIR = 5'h0c;
  localparam logic [4:0] OFS_PIN_FUNC = 5'h10;
  localparam logic [4:0] OFS_STATUS = 5'h14;
  localparam logic [4:0] OFS_PIN_IN = 5'h18;
  localparam logic [4:0] OFS_PIN_OE = 5'h1c;
  // Field positions
  localparam int LEVEL_BIT_POS = 0;
  localparam int SOSC_STOP_POS = 0;
  localparam int STAT_MAIN_OSC_POS = 4;
  localparam int STAT_SUB_OSC_POS = 5;
  localparam int STAT_LEVEL_POS = 6;
  // Reset values
  localparam logic [31:0] PIN_FUNC_RST = 32'h0000_0000;
  localparam logic [7:0] GPIO_RST = 8'h00;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Operating state as reported by the power controller
  typedef enum logic [3:0] {
    ST_POR = 4'b0000,
    ST_EXT_RESET = 4'b0001,
    ST_INT_RESET = 4'b0010,
    ST_RUN = 4'b0011,
    ST_TIMER = 4'b0100,
    ST_SUB_TIMER = 4'b0101,
    ST_SUBCR_TIMER = 4'b0110,
    ST_RTC = 4'b0111,
    ST_STOP = 4'b1000,
    ST_DS_RTC = 4'b1001,
    ST_DS_STOP = 4'b1010,
    ST_DS_RETURN = 4'b1011,
    ST_VBAT_RTC = 4'b1100,
    ST_VBAT_RETURN = 4'b1101
  } lpps_state_t;

  // Per-pin function select
  typedef enum logic [3:0] {
    FN_GPIO = 4'b0000,
    FN_ANA_IN = 4'b0001,
    FN_ANA_OUT = 4'b0010,
    FN_WAKEUP = 4'b0011,
    FN_EXT_INT = 4'b0100,
    FN_TRACE = 4'b0101,
    FN_RESOURCE = 4'b0110,
    FN_SOSC_IN = 4'b0111,
    FN_SOSC_OUT = 4'b1000
  } lpps_func_t;
endpackage : lpps_pkg

// [logic/lpps_pin_cell.sv]
`timescale 1ns/1ns
// One pad's output stage: registers the chosen state, or keeps it while held
module lpps_pin_cell
  import lpps_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic hold,
  input wire logic out_next,
  input wire logic oe_next,
  input wire logic din_en_next,
  input wire logic ana_next,
  input wire logic wk_next,
  input wire logic pad_in,
  output logic pad_out,
  output logic pad_oe,
  output logic core_in,
  output logic analog_en,
  output logic wakeup_en
);
  logic din_en_reg;

  // Drive state; a hold keeps the value from before the mode was entered
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pad_out <= 1'b0;
      pad_oe <= 1'b0;
      din_en_reg <= 1'b0;
      analog_en <= 1'b0;
      wakeup_en <= 1'b0;
    end
    else if (!hold)
    begin
      pad_out <= out_next;
      pad_oe <= oe_next;
      din_en_reg <= din_en_next;
      analog_en <= ana_next;
      wakeup_en <= wk_next;
    end
  end

  // Internal digital input, forced low when gated off
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      core_in <= 1'b0;
    else
      core_in <= din_en_reg & pad_in;
  end
endmodule : lpps_pin_cell

// [verification/lpps_top_asserts.sv]
`timescale 1ns/1ns
// Watches oscillator enables and register-bus handshakes at the top ports
module lpps_top_asserts
  import lpps_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic [3:0] op_state_in,
  input wire logic main_osc_en,
  input wire logic sub_osc_en
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // Settled state only, except the sub oscillator fall check: enables lag the state input by two edges
  a_main_osc_stop: assert property (
    $past(aresetn, 2) && $past(op_state_in, 2) == $past(op_state_in) && $past(op_state_in)
    inside {ST_SUB_TIMER, ST_SUBCR_TIMER, ST_RTC, ST_STOP, ST_DS_RTC, ST_DS_STOP} |-> !main_osc_en)
    else $error("main oscillator running in a stop state");
  a_main_osc_run: assert property (
    $past(aresetn, 2) && $past(op_state_in, 2) == ST_RUN && $past(op_state_in) == ST_RUN
    |-> main_osc_en)
    else $error("main oscillator stopped in run");
  a_sub_osc_fell: assert property (
    $fell(sub_osc_en) |-> $past(op_state_in, 2) inside {ST_STOP, ST_DS_STOP})
    else $error("sub oscillator stopped outside stop modes");
  a_sub_osc_run: assert property (
    $past(aresetn, 2) && $past(op_state_in, 2) == ST_RUN && $past(op_state_in) == ST_RUN
    |-> sub_osc_en)
    else $error("sub oscillator stopped in run");
  // Register bus answers and refusals
  a_wr_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_rd_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  a_b_clear: assert property (
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response not cleared");
  a_ar_refused: assert property (
    s_axi_rvalid |-> !s_axi_arready)
    else $error("read address accepted while answering");
  a_aw_refused: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while one is pending");
endmodule : lpps_top_asserts

bind lpps_top lpps_top_asserts u_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .op_state_in, .main_osc_en, .sub_osc_en);

// [verification/tb_lpps_top.sv]
`timescale 1ns/1ns
module tb_lpps_top
  import lpps_pkg::*;
;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic main_osc_en, sub_osc_en;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, seed, d;
  logic [3:0] s_axi_wstrb, op_state_in;
  logic [2:0] s_axi_awprot, s_axi_arprot;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [7:0] periph_out, periph_oe, pad_in, pad_out, pad_oe, core_in, analog_en, wakeup_en;
  logic [7:0] o, p, g;
  int fails, n_checks;
  lpps_state_t sl [8] = '{ST_RUN, ST_TIMER, ST_RTC, ST_STOP, ST_DS_RTC, ST_DS_STOP,
    ST_DS_RETURN, ST_INT_RESET};

  lpps_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .op_state_in, .periph_out, .periph_oe, .pad_in,
    .pad_out, .pad_oe, .core_in, .analog_en, .wakeup_en, .main_osc_en, .sub_osc_en);

  // Bench clock, 100 ns period
  initial
  begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  // Fixed-seed xorshift keeps runs repeatable
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  function automatic logic main_exp(lpps_state_t s);
    return !(s inside {ST_SUB_TIMER, ST_SUBCR_TIMER, ST_RTC, ST_STOP, ST_DS_RTC, ST_DS_STOP});
  endfunction : main_exp

  function automatic logic sub_exp(lpps_state_t s, logic b);
    return !(b && (s inside {ST_STOP, ST_DS_STOP}));
  endfunction : sub_exp

  task automatic ck(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : ck

  task automatic ck8(input logic [7:0] got, input logic [7:0] exp);
    ck({24'h0, got}, {24'h0, exp});
  endtask : ck8

  task automatic test_done();
    $display("checks=%0d mismatches=%0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : test_done

  // A wait that ran out ends the run as a failure
  task automatic lim(input int n);
    if (n >= 40)
    begin
      fails++;
      test_done();
    end
  endtask : lim

  // Address and data offered together; each released once taken
  task automatic wr(input logic [4:0] a, input logic [31:0] v);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= {27'h0, a};
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    n = 0;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid && n < 40);
    s_axi_bready <= 1'b0;
    lim(n);
    ck({30'h0, s_axi_bresp}, {30'h0, RESP_OKAY});
  endtask : wr

  task automatic rd(input logic [4:0] a, input logic [31:0] e);
    int n;
    @(posedge aclk);
    s_axi_araddr <= {27'h0, a};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    n = 0;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid && n < 40);
    s_axi_rready <= 1'b0;
    lim(n);
    ck(s_axi_rdata, e);
    ck({30'h0, s_axi_rresp}, {30'h0, RESP_OKAY});
  endtask : rd

  // Core inputs and the gated sub oscillator pin settle three edges late; four are given
  task automatic go(input lpps_state_t s);
    op_state_in <= s;
    repeat (4) @(posedge aclk);
  endtask : go

  initial
  begin
    seed = 32'h231e;
    fails = 0;
    n_checks = 0;
    aresetn = 1'b0;
    op_state_in = ST_RUN;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
    {s_axi_awprot, s_axi_arprot, s_axi_wstrb} = 10'h00f;
    {periph_out, periph_oe, pad_in} = '0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    // Reset values, status and read-back
    rd(OFS_PIN_FUNC, PIN_FUNC_RST);
    rd(OFS_STATUS, 32'h0000_0033);
    for (int i = 0; i < 3; i++)
    begin
      d = rnd();
      wr(OFS_GPIO_OUT, d);
      rd(OFS_GPIO_OUT, d & 32'hff);
    end
    wr(OFS_STANDBY_CTL, 32'h1);
    rd(OFS_STATUS, 32'h0000_0073);
    $display("test registers done");
    // Analog inputs across reset, run and standby states, both levels
    wr(OFS_PIN_FUNC, 32'h1111_1111);
    d = rnd();
    pad_in <= d[7:0];
    for (int b = 0; b < 2; b++)
    begin
      go(ST_RUN);
      wr(OFS_STANDBY_CTL, b);
      for (int i = 0; i < 8; i++)
      begin
        go(sl[i]);
        ck({8'h0, pad_oe, core_in, analog_en}, 32'h0000_00ff);
      end
    end
    $display("test analog input done");
    // Oscillator enables in every state from external reset to deep standby return, sub stop bit 0 then 1
    for (int b = 0; b < 2; b++)
    begin
      go(ST_RUN);
      wr(OFS_SUB_OSC_CTL, b);
      for (int s = 1; s < 12; s++)
      begin
        go(lpps_state_t'(4'(s)));
        ck8({7'h0, main_osc_en}, {7'h0, main_exp(lpps_state_t'(4'(s)))});
        ck8({7'h0, sub_osc_en}, {7'h0, sub_exp(lpps_state_t'(4'(s)), b[0])});
      end
    end
    $display("test oscillators done");
    // Analog outputs: held in timer, port or Hi-Z in RTC and stop
    go(ST_RUN);
    d = rnd();
    o = d[7:0];
    wr(OFS_GPIO_DIR, 32'hff);
    wr(OFS_GPIO_OUT, {24'h0, o});
    wr(OFS_PIN_FUNC, 32'h2222_2222);
    for (int b = 0; b < 2; b++)
    begin
      wr(OFS_STANDBY_CTL, b);
      go(ST_RUN);
      g = pad_oe;
      go(ST_TIMER);
      ck8(pad_oe, g);
      go(b ? ST_STOP : ST_RTC);
      ck8(core_in, 8'h00);
      ck8(pad_oe, b ? 8'h00 : 8'hff);
      if (!b) ck8(pad_out, o);
    end
    $display("test analog output done");
    // Deep standby: pins 7..4 wakeup, pins 3..0 port
    wr(OFS_PIN_FUNC, 32'h3333_0000);
    for (int b = 0; b < 2; b++)
    begin
      go(ST_RUN);
      wr(OFS_STANDBY_CTL, b);
      go(ST_DS_STOP);
      ck8(wakeup_en, 8'hf0);
      if (b) ck8(pad_oe & 8'hf0, 8'h00);
      if (!b) ck({20'h0, pad_oe[3:0], pad_out[3:0], core_in[3:0]}, {20'h0, 4'hf, o[3:0], 4'h0});
    end
    $display("test deep standby done");
    // Hold: peripheral pins keep following, port pins freeze
    go(ST_RUN);
    wr(OFS_STANDBY_CTL, 32'h0);
    wr(OFS_PIN_FUNC, 32'h0000_6666);
    d = rnd();
    periph_oe <= 8'hff;
    periph_out <= d[7:0];
    go(ST_RUN);
    go(ST_TIMER);
    d = rnd();
    p = d[7:0];
    periph_out <= p;
    wr(OFS_GPIO_OUT, {24'h0, ~o});
    go(ST_TIMER);
    ck8(pad_out, {o[7:4], p[3:0]});
    go(ST_RUN);
    ck8(pad_out, {~o[7:4], p[3:0]});
    $display("test hold done");
    // Sub-clock inputs stay enabled in every state
    wr(OFS_PIN_FUNC, 32'h7777_7777);
    d = rnd();
    pad_in <= d[7:0];
    for (int s = 0; s < 16; s++)
    begin
      go(lpps_state_t'(4'(s)));
      ck8(core_in, pad_in);
    end
    $display("test sub clock input done");
    // Sub oscillator output: off at power-on, Hi-Z once stopped (stop bit still 1)
    wr(OFS_PIN_FUNC, 32'h8888_8888);
    periph_oe <= 8'hff;
    go(ST_POR);
    ck8(pad_oe, 8'h00);
    ck8(core_in, 8'h00);
    go(ST_STOP);
    ck8({7'h0, sub_osc_en}, 8'h00);
    ck8(pad_oe, 8'h00);
    $display("test sub oscillator output done");
    test_done();
  end
endmodule : tb_lpps_top
